/* File: src/wakeup_pkg.sv */
package wakeup_pkg;

  // Source indices, in fixed priority order (lowest index wins)
  localparam int NSRC = 6;
  localparam int SRC_EXT = 0;
  localparam int SRC_PIN_CHANGE = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_CONV = 3;
  localparam int SRC_CMP = 4;
  localparam int SRC_LOW_VOLT = 5;

  // Per-source traits: has a wake enable, acts in sleep, acts in green
  localparam logic [NSRC-1:0] SRC_HAS_WE = 6'h3a;
  localparam logic [NSRC-1:0] SRC_IN_SLEEP = 6'h3a;
  localparam logic [NSRC-1:0] SRC_IN_GREEN = 6'h37;

  // Vector addresses
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_EXT = 8'h03;
  localparam logic [7:0] VEC_PIN_CHANGE = 8'h06;
  localparam logic [7:0] VEC_TIMER = 8'h09;
  localparam logic [7:0] VEC_CONV = 8'h0c;
  localparam logic [7:0] VEC_CMP = 8'h0f;
  localparam logic [7:0] VEC_LOW_VOLT = 8'h18;

  // Register word indices (byte address is four times the index)
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h0;
  localparam logic [2:0] OFS_WAKE_ENABLE = 3'h1;
  localparam logic [2:0] OFS_IRQ_PENDING = 3'h2;
  localparam logic [2:0] OFS_LOW_VOLT_CTRL = 3'h3;
  localparam logic [2:0] OFS_MODE_CTRL = 3'h4;
  localparam logic [2:0] OFS_EVT_STATUS = 3'h5;
  localparam logic [2:0] OFS_EVT_MASK = 3'h6;

  // Field positions in the enable and pending layouts
  localparam int BIT_TIMER = 0;
  localparam int BIT_PIN_CHANGE = 1;
  localparam int BIT_EXT = 2;
  localparam int BIT_CONV = 3;
  localparam int BIT_CMP = 7;
  localparam int WBIT_PIN_CHANGE = 0;
  localparam int WBIT_CMP = 1;
  localparam int WBIT_CONV = 2;
  localparam int LVBIT_WAKE = 3;
  localparam int LVBIT_IE = 4;
  localparam int LVBIT_PEND = 6;
  localparam int MBIT_GIE = 4;

  // Event status bits
  localparam int EVT_WAKE = 0;
  localparam int EVT_VECTOR = 1;
  localparam int EVT_RESET = 2;
  localparam int EVT_PEND_SET = 3;
  localparam int NEVT = 4;

  typedef enum logic [3:0] {
    PM_NORMAL = 4'h1,
    PM_GREEN = 4'h2,
    PM_IDLE = 4'h4,
    PM_SLEEP = 4'h8
  } pmode_t;

  typedef struct packed {
    logic [NSRC-1:0] src;
    logic wdt_timeout;
    logic low_volt_reset;
  } evt_in_t;

  typedef struct packed {
    logic wake;
    logic resume;
    logic vreq;
    logic [7:0] vaddr;
    logic rst_req;
  } disp_out_t;

  typedef struct packed {
    logic main_run;
    logic sub_run;
    logic tmr_run;
  } clk_ctl_t;

  typedef struct packed {
    logic [NSRC-1:0] ie;
    logic [NSRC-1:0] we;
    logic [NSRC-1:0] pend;
    pmode_t mode;
    logic gie;
    logic [NEVT-1:0] evt_st;
    logic [NEVT-1:0] evt_mask;
    logic waitreq;
    logic [31:0] rdata;
    disp_out_t dout;
    clk_ctl_t clk;
    logic irq;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    ie: '0, we: '0, pend: '0, mode: PM_NORMAL, gie: 1'b0,
    evt_st: '0, evt_mask: '0, waitreq: 1'b1, rdata: '0,
    dout: '0, clk: '{main_run: 1'b1, sub_run: 1'b1, tmr_run: 1'b1},
    irq: 1'b0};

  function automatic logic [7:0] to_irq_layout(logic [NSRC-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[BIT_TIMER] = v[SRC_TIMER];
    r[BIT_PIN_CHANGE] = v[SRC_PIN_CHANGE];
    r[BIT_EXT] = v[SRC_EXT];
    r[BIT_CONV] = v[SRC_CONV];
    r[BIT_CMP] = v[SRC_CMP];
    return r;
  endfunction

  function automatic logic [NSRC-1:0] from_irq_layout(logic [7:0] r,
                                                       logic lv);
    logic [NSRC-1:0] v;
    v = '0;
    v[SRC_TIMER] = r[BIT_TIMER];
    v[SRC_PIN_CHANGE] = r[BIT_PIN_CHANGE];
    v[SRC_EXT] = r[BIT_EXT];
    v[SRC_CONV] = r[BIT_CONV];
    v[SRC_CMP] = r[BIT_CMP];
    v[SRC_LOW_VOLT] = lv;
    return v;
  endfunction

endpackage

/* File: src/src_route.sv */
`timescale 1ns/100ps
`default_nettype none

module src_route #(
  parameter bit HAS_WE = 1'b1,
  parameter bit IN_SLEEP = 1'b1,
  parameter bit IN_GREEN = 1'b1
) (
  input wire wakeup_pkg::pmode_t mode,
  input wire logic evt,
  input wire logic ie,
  input wire logic we,
  output logic set_pend,
  output logic wake,
  output logic vect_ok
);
  import wakeup_pkg::*;

  logic active;
  logic low_power;

  always_comb begin
    low_power = (mode == PM_SLEEP) || (mode == PM_IDLE);
    active = evt && !((mode == PM_SLEEP) && !IN_SLEEP)
      && !((mode == PM_GREEN) && !IN_GREEN);
    set_pend = active && ie;
    // Sources without a wake enable wake from idle through their irq enable
    wake = active && low_power && (HAS_WE ? we : ie);
    vect_ok = active && ie && (!low_power || wake);
  end

endmodule // src_route

`default_nettype wire

/* File: src/vector_pick.sv */
`timescale 1ns/100ps
`default_nettype none

module vector_pick #(
  parameter int N = 6
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [N-1:0] grant,
  output logic [7:0] addr
);
  import wakeup_pkg::*;

  function automatic logic [7:0] vec_of(int i);
    unique case (i)
      SRC_EXT: return VEC_EXT;
      SRC_PIN_CHANGE: return VEC_PIN_CHANGE;
      SRC_TIMER: return VEC_TIMER;
      SRC_CONV: return VEC_CONV;
      SRC_CMP: return VEC_CMP;
      default: return VEC_LOW_VOLT;
    endcase
  endfunction

  always_comb begin
    any = 1'b0;
    grant = '0;
    addr = VEC_RESET;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = '0;
        grant[i] = 1'b1;
        addr = vec_of(i);
        any = 1'b1;
      end
    end
  end

endmodule // vector_pick

`default_nettype wire

/* File: src/wakeup_irq_dispatch.sv */
// Operation
// - Normal mode, ext enabled, global off: set ext pending, next instruction.
// - Normal mode, ext and global enabled: set ext pending, vector 0x03.
// - Pin-change irq enable clear: port changes ignored in normal mode.
// - Sleep, no pin wake, pin irq on: pending only, stay asleep, clocks off.
// - Sleep, pin wake on, irq off: wake, next instruction, no pending.
// - Sleep, pin wake and irq on, global off: wake, pending, next instruction.
// - Sleep, pin wake, irq and global on: wake, pending, vector 0x06.
// - Normal, pin irq on: pending, vector 0x06 if global on else continue.
// - Normal, timer irq on, global off: timer pending, next instruction.
// - Normal, timer irq and global on: timer pending, vector 0x09.
// - Converter wakes sleep/idle only with wake enable; main and sub clocks keep running.
// - Comparator wakes sleep/idle only with wake enable; else plain source.
// - Low-voltage wakes sleep/idle only with wake enable; then irq or continue.
// - Enabled watchdog timeout or low-voltage reset: reset to 0x00, any mode.
// - Converter irq and global on: converter pending, vector 0x0C.
// - Comparator irq and global on: comparator pending, vector 0x0F.
// - Low-voltage irq and global on: low-voltage pending, vector 0x18.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module wakeup_irq_dispatch (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire wakeup_pkg::evt_in_t evt_in,
  input wire logic wdt_enable,
  input wire logic global_irq_on_op,
  input wire logic global_irq_off_op,
  output wakeup_pkg::disp_out_t disp_out,
  output wakeup_pkg::clk_ctl_t clk_ctl,
  output logic irq_out
);
  import wakeup_pkg::*;

  core_state_t st_r;
  core_state_t st_nxt;
  logic [NSRC-1:0] set_p;
  logic [NSRC-1:0] wake_v;
  logic [NSRC-1:0] vok;
  logic [NSRC-1:0] we_eff;
  logic [NSRC-1:0] grant;
  logic v_any;
  logic [7:0] v_addr;
  logic bus_take;
  logic sw_wr;

  // Watchdog running locks out every wake enable
  assign we_eff = st_r.we & {NSRC{!wdt_enable}};

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    src_route #(
      .HAS_WE(SRC_HAS_WE[i]),
      .IN_SLEEP(SRC_IN_SLEEP[i]),
      .IN_GREEN(SRC_IN_GREEN[i])
    ) u_route (
      .mode(st_r.mode),
      .evt(evt_in.src[i]),
      .ie(st_r.ie[i]),
      .we(we_eff[i]),
      .set_pend(set_p[i]),
      .wake(wake_v[i]),
      .vect_ok(vok[i])
    );
  end

  vector_pick #(
    .N(NSRC)
  ) u_pick (
    .req(vok & {NSRC{st_r.gie}}),
    .any(v_any),
    .grant(grant),
    .addr(v_addr)
  );

  // One wait state: address taken on first edge, access done on second
  assign bus_take = !st_r.waitreq && (avs_read || avs_write);
  assign sw_wr = bus_take && avs_write;

  always_comb begin
    logic [31:0] rd;
    logic [3:0] wm;
    logic rst_evt;
    rd = 32'h0000_0000;
    wm = avs_writedata[3:0];
    rst_evt = (evt_in.wdt_timeout && wdt_enable) || evt_in.low_volt_reset;
    st_nxt = st_r;
    st_nxt.dout.wake = 1'b0;
    st_nxt.dout.resume = 1'b0;
    st_nxt.dout.vreq = 1'b0;
    st_nxt.dout.rst_req = 1'b0;

    unique case (avs_address)
      OFS_IRQ_ENABLE: rd[7:0] = to_irq_layout(st_r.ie);
      OFS_WAKE_ENABLE: begin
        rd[WBIT_PIN_CHANGE] = st_r.we[SRC_PIN_CHANGE];
        rd[WBIT_CMP] = st_r.we[SRC_CMP];
        rd[WBIT_CONV] = st_r.we[SRC_CONV];
      end
      OFS_IRQ_PENDING: rd[7:0] = to_irq_layout(st_r.pend);
      OFS_LOW_VOLT_CTRL: begin
        rd[LVBIT_WAKE] = st_r.we[SRC_LOW_VOLT];
        rd[LVBIT_IE] = st_r.ie[SRC_LOW_VOLT];
        rd[LVBIT_PEND] = st_r.pend[SRC_LOW_VOLT];
      end
      OFS_MODE_CTRL: rd[MBIT_GIE:0] = {st_r.gie, st_r.mode};
      OFS_EVT_STATUS: rd[NEVT-1:0] = st_r.evt_st;
      OFS_EVT_MASK: rd[NEVT-1:0] = st_r.evt_mask;
      default: rd = 32'h0000_0000;
    endcase

    if (st_r.waitreq) begin
      if (avs_read || avs_write) begin
        st_nxt.waitreq = 1'b0;
        st_nxt.rdata = rd;
      end
    end else begin
      st_nxt.waitreq = 1'b1;
    end

    // Software side first so that hardware sets below win
    if (bus_take && avs_read && avs_address == OFS_EVT_STATUS) begin
      st_nxt.evt_st = '0;
    end
    if (sw_wr) begin
      unique case (avs_address)
        OFS_IRQ_ENABLE: begin
          st_nxt.ie = from_irq_layout(avs_writedata[7:0],
                                      st_r.ie[SRC_LOW_VOLT]);
        end
        OFS_WAKE_ENABLE: begin
          st_nxt.we[SRC_PIN_CHANGE] = avs_writedata[WBIT_PIN_CHANGE];
          st_nxt.we[SRC_CMP] = avs_writedata[WBIT_CMP];
          st_nxt.we[SRC_CONV] = avs_writedata[WBIT_CONV];
        end
        OFS_IRQ_PENDING: begin
          // Writing zero clears a flag, writing one leaves it
          st_nxt.pend = st_r.pend & from_irq_layout(avs_writedata[7:0],
                                                    1'b1);
        end
        OFS_LOW_VOLT_CTRL: begin
          st_nxt.we[SRC_LOW_VOLT] = avs_writedata[LVBIT_WAKE];
          st_nxt.ie[SRC_LOW_VOLT] = avs_writedata[LVBIT_IE];
          st_nxt.pend[SRC_LOW_VOLT] = st_r.pend[SRC_LOW_VOLT]
            && avs_writedata[LVBIT_PEND];
        end
        OFS_MODE_CTRL: begin
          st_nxt.gie = avs_writedata[MBIT_GIE];
          // Illegal mode codes leave the mode alone
          if ($onehot(wm)) begin
            st_nxt.mode = pmode_t'(wm);
          end
        end
        OFS_EVT_MASK: st_nxt.evt_mask = avs_writedata[NEVT-1:0];
        default: st_nxt.mode = st_nxt.mode;
      endcase
    end

    if (global_irq_on_op) begin
      st_nxt.gie = 1'b1;
    end
    if (global_irq_off_op) begin
      st_nxt.gie = 1'b0;
    end

    st_nxt.pend = st_nxt.pend | set_p;
    if (|wake_v) begin
      st_nxt.mode = PM_NORMAL;
      st_nxt.dout.wake = 1'b1;
      st_nxt.dout.resume = !v_any;
    end
    if (v_any) begin
      // Taking a vector masks further vectors until re-enabled
      st_nxt.gie = 1'b0;
      st_nxt.dout.vreq = 1'b1;
      st_nxt.dout.vaddr = v_addr;
    end

    if (rst_evt) begin
      st_nxt.dout.rst_req = 1'b1;
      st_nxt.dout.vreq = 1'b0;
      st_nxt.dout.resume = 1'b0;
      st_nxt.dout.vaddr = VEC_RESET;
      st_nxt.dout.wake = (st_r.mode != PM_NORMAL);
      st_nxt.mode = PM_NORMAL;
      st_nxt.ie = '0;
      st_nxt.pend = '0;
      st_nxt.gie = 1'b0;
    end

    st_nxt.evt_st[EVT_WAKE] = st_nxt.evt_st[EVT_WAKE] || st_nxt.dout.wake;
    st_nxt.evt_st[EVT_VECTOR] = st_nxt.evt_st[EVT_VECTOR]
      || st_nxt.dout.vreq;
    st_nxt.evt_st[EVT_RESET] = st_nxt.evt_st[EVT_RESET] || rst_evt;
    st_nxt.evt_st[EVT_PEND_SET] = st_nxt.evt_st[EVT_PEND_SET]
      || ((|set_p) && !rst_evt);

    // Converter wake keeps both clocks alive in sleep and idle
    st_nxt.clk.main_run = (st_nxt.mode == PM_NORMAL)
      || (st_nxt.we[SRC_CONV] && !wdt_enable);
    st_nxt.clk.sub_run = (st_nxt.mode != PM_SLEEP)
      || (st_nxt.we[SRC_CONV] && !wdt_enable);
    st_nxt.clk.tmr_run = (st_nxt.mode != PM_SLEEP);
    st_nxt.irq = |(st_nxt.evt_st & st_nxt.evt_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign disp_out = st_r.dout;
  assign clk_ctl = st_r.clk;
  assign irq_out = st_r.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Helper: no reset event, no software write, no global op this cycle
  logic quiet;
  assign quiet = !evt_in.wdt_timeout && !evt_in.low_volt_reset && !sw_wr
    && !global_irq_on_op && !global_irq_off_op;

  sequence s_normal_only(logic [NSRC-1:0] pat);
    quiet && st_r.mode == PM_NORMAL && evt_in.src == pat;
  endsequence

  sequence s_sleep_pin(logic w, logic ie, logic g);
    quiet && !wdt_enable && st_r.mode == PM_SLEEP && evt_in.src == 6'h02
      && st_r.we[SRC_PIN_CHANGE] == w && st_r.ie[SRC_PIN_CHANGE] == ie
      && st_r.gie == g;
  endsequence

  a_ext_no_vector: assert property (
    s_normal_only(6'h01) ##0 (st_r.ie[SRC_EXT] && !st_r.gie)
    |=> st_r.pend[SRC_EXT] && !st_r.dout.vreq)
    else $error("ext event without global enable vectored");

  a_ext_vector: assert property (
    s_normal_only(6'h01) ##0 (st_r.ie[SRC_EXT] && st_r.gie)
    |=> st_r.dout.vreq && st_r.dout.vaddr == VEC_EXT && !st_r.gie)
    else $error("ext event did not vector to its address");

  a_pin_ignored: assert property (
    s_normal_only(6'h02) ##0 !st_r.ie[SRC_PIN_CHANGE]
    |=> !$rose(st_r.pend[SRC_PIN_CHANGE]) && !st_r.dout.vreq)
    else $error("disabled pin change acted as a source");

  a_sleep_flag_only: assert property (
    s_sleep_pin(1'b0, 1'b1, 1'b0)
    |=> st_r.pend[SRC_PIN_CHANGE] && st_r.mode == PM_SLEEP
      && !st_r.dout.wake && !st_r.clk.tmr_run)
    else $error("pin change woke sleep without wake enable");

  a_sleep_wake_resume: assert property (
    s_sleep_pin(1'b1, 1'b0, 1'b0)
    |=> st_r.dout.wake && st_r.dout.resume && !st_r.dout.vreq
      && !$rose(st_r.pend[SRC_PIN_CHANGE]) ##1 st_r.mode == PM_NORMAL)
    else $error("pin wake without irq did not resume cleanly");

  a_sleep_wake_vector: assert property (
    s_sleep_pin(1'b1, 1'b1, 1'b1)
    |=> st_r.dout.wake && st_r.dout.vreq
      && st_r.dout.vaddr == VEC_PIN_CHANGE && st_r.pend[SRC_PIN_CHANGE])
    else $error("pin wake with irq did not vector");

  a_timer_vector: assert property (
    s_normal_only(6'h04) ##0 (st_r.ie[SRC_TIMER] && st_r.gie)
    |=> st_r.dout.vreq && st_r.dout.vaddr == VEC_TIMER)
    else $error("timer overflow did not vector");

  a_wdt_reset: assert property (
    (evt_in.wdt_timeout && wdt_enable)
    |=> st_r.dout.rst_req && st_r.dout.vaddr == VEC_RESET
      && st_r.mode == PM_NORMAL && st_r.pend == '0)
    else $error("watchdog timeout did not reset");

  // Judged one edge on only: a later write or wake may move the mode
  a_ext_no_sleep_wake: assert property (
    quiet && st_r.mode == PM_SLEEP && evt_in.src != '0
      && (evt_in.src & 6'h05) == evt_in.src
    |=> !st_r.dout.wake && st_r.mode == PM_SLEEP)
    else $error("ext pin or timer woke sleep");

  a_pin_sleep_resume: assert property (
    s_sleep_pin(1'b1, 1'b1, 1'b0)
    |=> st_r.dout.wake && st_r.dout.resume && !st_r.dout.vreq
      && st_r.pend[SRC_PIN_CHANGE])
    else $error("pin wake with global off did not resume");

  a_conv_no_green: assert property (
    quiet && st_r.mode == PM_GREEN && evt_in.src == 6'h08
    |=> !st_r.dout.wake && !st_r.dout.vreq
      && !$rose(st_r.pend[SRC_CONV]))
    else $error("converter acted in green mode");

  a_lv_vector: assert property (
    quiet && !wdt_enable && st_r.mode == PM_SLEEP && evt_in.src == 6'h20
      && st_r.we[SRC_LOW_VOLT] && st_r.ie[SRC_LOW_VOLT] && st_r.gie
    |=> st_r.dout.vreq && st_r.dout.vaddr == VEC_LOW_VOLT
      && st_r.pend[SRC_LOW_VOLT])
    else $error("low-voltage event did not vector");

endmodule // wakeup_irq_dispatch

`default_nettype wire

/* File: bench/event_seq_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Sequencer and event sources; keeps what each dispatch told it
module event_seq_model (
  input wire logic clk_sys,
  input wire logic fire,
  input wire wakeup_pkg::evt_in_t pat,
  input wire logic on_req,
  input wire logic off_req,
  input wire wakeup_pkg::disp_out_t disp_out,
  output wakeup_pkg::evt_in_t evt_in,
  output logic global_irq_on_op,
  output logic global_irq_off_op,
  output wakeup_pkg::disp_out_t seen
);
  import wakeup_pkg::*;

  initial begin
    evt_in = '0;
    global_irq_on_op = 1'b0;
    global_irq_off_op = 1'b0;
    seen = '0;
  end

  // Pulses last one cycle, so they are gathered, not sampled late
  always @(posedge clk_sys) begin
    evt_in <= fire ? pat : '0;
    global_irq_on_op <= on_req;
    global_irq_off_op <= off_req;
    if (fire) begin
      seen <= '0;
    end else begin
      seen.wake <= seen.wake | disp_out.wake;
      seen.resume <= seen.resume | disp_out.resume;
      seen.vreq <= seen.vreq | disp_out.vreq;
      seen.rst_req <= seen.rst_req | disp_out.rst_req;
      // Address only counts when a branch is asked for
      if (disp_out.vreq | disp_out.rst_req) begin
        seen.vaddr <= disp_out.vaddr;
      end
    end
  end
endmodule // event_seq_model

`default_nettype wire

/* File: bench/tb_wakeup_interrupt_dispatch.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_wakeup_interrupt_dispatch;
  import wakeup_pkg::*;
  localparam disp_out_t NONE = '0;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wdt_enable = 1'b0;
  logic fire = 1'b0;
  logic on_req = 1'b0;
  logic off_req = 1'b0;
  evt_in_t pat = '0;
  evt_in_t evt_in;
  logic on_op;
  logic off_op;
  disp_out_t disp_out;
  disp_out_t seen;
  clk_ctl_t clk_ctl;
  logic irq_out;
  logic [31:0] rd;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  wakeup_irq_dispatch dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .evt_in(evt_in), .wdt_enable(wdt_enable),
    .global_irq_on_op(on_op), .global_irq_off_op(off_op),
    .disp_out(disp_out), .clk_ctl(clk_ctl), .irq_out(irq_out));

  event_seq_model partner_u (.clk_sys(clk_sys), .fire(fire), .pat(pat),
    .on_req(on_req), .off_req(off_req), .disp_out(disp_out),
    .evt_in(evt_in), .global_irq_on_op(on_op),
    .global_irq_off_op(off_op), .seen(seen));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung handshake must still reach the verdict
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
               got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(32'(n), 32'h0000_0002, "wait states");
  endtask

  task automatic gie_op(input logic on);
    @(posedge clk_sys);
    on_req <= on;
    off_req <= !on;
    @(posedge clk_sys);
    on_req <= 1'b0;
    off_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic su(input pmode_t m, input logic g, input logic [7:0] ie,
                    input logic [7:0] we, input logic [7:0] lv);
    bus(1'b1, OFS_IRQ_ENABLE, {24'h00_0000, ie});
    bus(1'b1, OFS_WAKE_ENABLE, {24'h00_0000, we});
    bus(1'b1, OFS_LOW_VOLT_CTRL, {24'h00_0000, lv});
    bus(1'b1, OFS_IRQ_PENDING, 32'h0000_0000);
    bus(1'b1, OFS_MODE_CTRL, {28'h000_0000, m});
    gie_op(g);
  endtask

  function automatic evt_in_t sp(input int i);
    evt_in_t p;
    p = '0;
    p.src[i] = 1'b1;
    return p;
  endfunction

  function automatic disp_out_t dx(input logic w, input logic r,
      input logic v, input logic [7:0] a, input logic rs);
    return '{wake: w, resume: r, vreq: v, vaddr: a, rst_req: rs};
  endfunction

  task automatic fire_evt(input evt_in_t p);
    @(posedge clk_sys);
    fire <= 1'b1;
    pat <= p;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic run(input evt_in_t p, input disp_out_t e,
                     input logic [7:0] pend);
    fire_evt(p);
    chk(32'(seen), 32'(e), "dispatch");
    bus(1'b0, OFS_IRQ_PENDING, 32'h0000_0000);
    chk(rd, {24'h00_0000, pend}, "pending");
  endtask

  task automatic t_reset();
    chk(32'(clk_ctl), 32'h0000_0007, "clocks after reset");
    chk(32'(irq_out), 32'h0000_0000, "irq after reset");
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 3'(i), 32'h0000_0000);
      chk(rd, (3'(i) == OFS_MODE_CTRL) ? 32'(PM_NORMAL) : 32'h0000_0000,
          "reset value");
    end
    bus(1'b1, 3'h7, 32'hffff_ffff);
    bus(1'b0, 3'h7, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
  endtask

  task automatic t_ext();
    su(PM_NORMAL, '0, 8'h04, '0, '0);
    run(sp(SRC_EXT), NONE, 8'h04);
    repeat (5) @(posedge clk_sys);
    bus(1'b0, OFS_IRQ_PENDING, 32'h0000_0000);
    chk(rd, 32'h0000_0004, "ext sticky");
    gie_op('1);
    run(sp(SRC_EXT), dx('0, '0, '1, VEC_EXT, '0), 8'h04);
    su(PM_SLEEP, '1, 8'h04, 8'h07, '0);
    run(sp(SRC_EXT), NONE, 8'h00);
    su(PM_IDLE, '0, 8'h04, '0, '0);
    run(sp(SRC_EXT), dx('1, '1, '0, '0, '0), 8'h04);
  endtask

  task automatic t_pin();
    su(PM_NORMAL, '1, '0, '0, '0);
    run(sp(SRC_PIN_CHANGE), NONE, 8'h00);
    su(PM_SLEEP, '0, 8'h02, '0, '0);
    run(sp(SRC_PIN_CHANGE), NONE, 8'h02);
    chk(32'({clk_ctl.main_run, clk_ctl.tmr_run}), 32'h0, "stopped");
    su(PM_SLEEP, '0, '0, 8'h01, '0);
    run(sp(SRC_PIN_CHANGE), dx('1, '1, '0, '0, '0), 8'h00);
    su(PM_SLEEP, '0, 8'h02, 8'h01, '0);
    run(sp(SRC_PIN_CHANGE), dx('1, '1, '0, '0, '0), 8'h02);
    su(PM_SLEEP, '1, 8'h02, 8'h01, '0);
    run(sp(SRC_PIN_CHANGE), dx('1, '0, '1, VEC_PIN_CHANGE, '0), 8'h02);
    su(PM_NORMAL, '0, 8'h02, '0, '0);
    run(sp(SRC_PIN_CHANGE), NONE, 8'h02);
    su(PM_NORMAL, '1, 8'h02, '0, '0);
    run(sp(SRC_PIN_CHANGE), dx('0, '0, '1, VEC_PIN_CHANGE, '0), 8'h02);
  endtask

  task automatic t_timer_conv();
    su(PM_NORMAL, '0, 8'h01, '0, '0);
    run(sp(SRC_TIMER), NONE, 8'h01);
    su(PM_NORMAL, '1, 8'h01, '0, '0);
    run(sp(SRC_TIMER), dx('0, '0, '1, VEC_TIMER, '0), 8'h01);
    su(PM_SLEEP, '1, 8'h01, 8'h07, '0);
    run(sp(SRC_TIMER), NONE, 8'h00);
    su(PM_IDLE, '0, 8'h01, '0, '0);
    run(sp(SRC_TIMER), dx('1, '1, '0, '0, '0), 8'h01);
    su(PM_GREEN, '1, 8'h08, 8'h04, '0);
    run(sp(SRC_CONV), NONE, 8'h00);
    su(PM_SLEEP, '0, '0, 8'h04, '0);
    chk(32'({clk_ctl.main_run, clk_ctl.sub_run}), 32'h3, "running");
    run(sp(SRC_CONV), dx('1, '1, '0, '0, '0), 8'h00);
    su(PM_IDLE, '0, '0, '0, '0);
    run(sp(SRC_CONV), NONE, 8'h00);
    su(PM_NORMAL, '1, 8'h08, '0, '0);
    run(sp(SRC_CONV), dx('0, '0, '1, VEC_CONV, '0), 8'h08);
  endtask

  task automatic t_cmp_lv();
    su(PM_SLEEP, '0, 8'h80, '0, '0);
    run(sp(SRC_CMP), NONE, 8'h80);
    su(PM_IDLE, '0, '0, 8'h02, '0);
    run(sp(SRC_CMP), dx('1, '1, '0, '0, '0), 8'h00);
    su(PM_GREEN, '1, 8'h80, 8'h02, '0);
    run(sp(SRC_CMP), dx('0, '0, '1, VEC_CMP, '0), 8'h80);
    su(PM_SLEEP, '0, '0, '0, 8'h08);
    run(sp(SRC_LOW_VOLT), dx('1, '1, '0, '0, '0), 8'h00);
    su(PM_SLEEP, '1, '0, '0, 8'h18);
    run(sp(SRC_LOW_VOLT), dx('1, '0, '1, VEC_LOW_VOLT, '0), 8'h00);
    bus(1'b0, OFS_LOW_VOLT_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0058, "low-volt pending");
  endtask

  task automatic t_rst();
    su(PM_SLEEP, '0, 8'h04, '0, '0);
    wdt_enable <= 1'b1;
    fire_evt(evt_in_t'(8'h02));
    chk(32'({seen.wake, seen.vreq, seen.vaddr, seen.rst_req}), 32'h401, "wdt");
    wdt_enable <= 1'b0;
    su(PM_NORMAL, '0, '0, '0, '0);
    fire_evt(evt_in_t'(8'h01));
    chk(32'({seen.wake, seen.vreq, seen.vaddr, seen.rst_req}), 32'h1, "lvr");
    su(PM_IDLE, '0, '0, '0, '0);
    fire_evt(evt_in_t'(8'h02));
    chk(32'(seen.rst_req), 32'h0, "wdt off");
  endtask

  // Status and mask path of the level interrupt output
  task automatic t_irq();
    bus(1'b1, OFS_EVT_MASK, 32'h0000_0000);
    su(PM_NORMAL, '1, 8'h04, '0, '0);
    bus(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    fire_evt(sp(SRC_EXT));
    chk(32'(irq_out), 32'h0, "masked irq");
    bus(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_000a, "status");
    bus(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status cleared");
    bus(1'b1, OFS_EVT_MASK, 32'h0000_0002);
    gie_op('1);
    fire_evt(sp(SRC_EXT));
    chk(32'(irq_out), 32'h1, "irq raised");
    bus(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    repeat (2) @(negedge clk_sys);
    chk(32'(irq_out), 32'h0, "irq dropped");
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    t_reset();
    t_ext();
    t_pin();
    t_timer_conv();
    t_cmp_lv();
    t_rst();
    t_irq();
    report_and_stop();
  end
endmodule // tb_wakeup_interrupt_dispatch

`default_nettype wire
